// file: src/adc_ctrl_pkg.sv
// Purpose: Shared constants for the serial control-byte front end.
// Assumes: Control byte is sent MSB first, start bit first.
// Notes:   Core clock 50 MHz, serial clock comes from the master.

package adc_ctrl_pkg;

    // ------------------------------------------------------------
    // Control byte field positions
    // ------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int START_BIT = 7;
    localparam int SEL_HI_BIT = 6;
    localparam int SEL_LO_BIT = 4;
    localparam int POLARITY_BIT = 3;
    localparam int INPUT_MODE_BIT = 2;
    localparam int PWR_HI_BIT = 1;
    localparam int PWR_LO_BIT = 0;

    // ------------------------------------------------------------
    // Bit counter marks (start bit counts as the first bit)
    // ------------------------------------------------------------
    localparam logic [3:0] CNT_IDLE = 4'h0;
    localparam logic [3:0] CNT_FIRST = 4'h1;
    localparam logic [3:0] CNT_TRACK = 4'h5;
    localparam logic [3:0] CNT_FULL = 4'h8;

    // ------------------------------------------------------------
    // Channel select codes
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_A = 3'h1;
    localparam logic [2:0] SEL_B = 3'h5;
    localparam logic [2:0] SEL_C = 3'h2;
    localparam logic [2:0] SEL_D = 3'h6;

    // ------------------------------------------------------------
    // Power / clock field codes
    // ------------------------------------------------------------
    localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
    localparam logic [1:0] PWR_FAST_DOWN = 2'h1;
    localparam logic [1:0] PWR_INT_CLK = 2'h2;
    localparam logic [1:0] PWR_EXT_CLK = 2'h3;

    // ------------------------------------------------------------
    // Reset values of decoded outputs
    // ------------------------------------------------------------
    localparam logic [3:0] CH_NONE = 4'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CORE_CLK_HZ = 50_000_000;
    localparam int ACQUIRE_TIME_NS = 1500;
    localparam int ACQUIRE_TIME_CYC =
        (ACQUIRE_TIME_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;

    // ------------------------------------------------------------
    // Core state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;

endpackage : adc_ctrl_pkg

// file: src/sync_2ff.sv
// Purpose: Two-flop level synchroniser, one stage pair per bit.
// Assumes: Inputs are levels or toggles held longer than two clocks.
// Notes:   The first stage feeds only the second stage.

`timescale 1ns/10ps

module sync_2ff #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ------------------------------------------------------------
    // Per-bit stages
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_q <= 1'b0;
                    q[i] <= 1'b0;
                end else if (ce) begin
                    meta_q <= d[i];
                    q[i] <= meta_q;
                end
            end
        end
    endgenerate

endmodule : sync_2ff

// file: src/adc_serial_control_byte_sampler.sv
// Purpose: Serial control-byte front end of a four-channel converter.
// Assumes: Serial clock idles low; data in is stable at its rising edge.
// Notes:   Serial logic runs on SCLK; decode and mux run on CORE_CLK.
//
// What this block does
// - Start tracking on the falling serial edge after the fifth bit.
// - Switch tracking to hold on the falling edge after the eighth bit.
// - Single-ended: negative input goes to common pin, sample positive.
// - Differential: negative input goes to the pair's negative channel.
// - After conversion finishes, reconnect hold capacitor to positive.
// - First one after chip select falls is the start bit, bit 7.
// - Zeros before the start bit are ignored without state change.
// - With chip select low, shift one bit per rising serial edge.
// - A conversion begins only after a complete control byte.
// - Bit 3 one selects unipolar, zero selects bipolar conversion.
// - Bits 1 and 0 pick clock mode; 11 means external clock.
// - Conversion starts on the falling edge after the eighth bit.
// - Differential codes 001,010,101,110 pick 0+1-,2+3-,0-1+,2-3+.

`timescale 1ns/10ps

module adc_serial_control_byte_sampler
    import adc_ctrl_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic DIN,
    input wire logic CONV_DONE,
    output logic TH_TRACK,
    output logic CONV_START,
    output logic CONV_BUSY,
    output logic CHOLD_ON_NEG,
    output logic [3:0] POS_CH_SEL,
    output logic [3:0] NEG_CH_SEL,
    output logic NEG_TO_COM,
    output logic SEL_INVALID,
    output logic UNIPOLAR,
    output logic PWR_DOWN_FULL,
    output logic PWR_DOWN_FAST,
    output logic INT_CLK_MODE,
    output logic EXT_CLK_MODE
);

    // ------------------------------------------------------------
    // Serial domain: framing reset
    // ------------------------------------------------------------
    // Chip select high clears the framing; the clock may stop then.
    logic link_rst;
    assign link_rst = CS_N | RESET;

    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    logic [5:0] shift_q;
    logic [5:0] shift_d;
    logic [BYTE_W-1:0] byte_q;
    logic track_q;
    logic conv_tgl_q;

    // ------------------------------------------------------------
    // Serial domain: start detection and shifting
    // ------------------------------------------------------------
    always_comb begin
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        if (bit_cnt_q == CNT_IDLE || bit_cnt_q == CNT_FULL) begin
            if (DIN) begin
                bit_cnt_d = CNT_FIRST;
            end else begin
                bit_cnt_d = CNT_IDLE;
            end
            shift_d = shift_q;
        end else begin
            bit_cnt_d = bit_cnt_q + 4'h1;
            shift_d = {shift_q[4:0], DIN};
        end
    end

    always_ff @(posedge SCLK or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_q <= CNT_IDLE;
            shift_q <= 6'h00;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
        end
    end

    // Byte register survives chip select so the core can read it late
    always_ff @(posedge SCLK or posedge RESET) begin
        if (RESET) begin
            byte_q <= 8'h00;
        end else if (!CS_N && bit_cnt_d == CNT_FULL
                     && bit_cnt_q != CNT_FULL) begin
            byte_q <= {1'b1, shift_q[5:0], DIN};
        end
    end

    // ------------------------------------------------------------
    // Serial domain: track/hold on falling edges
    // ------------------------------------------------------------
    always_ff @(negedge SCLK or posedge link_rst) begin
        if (link_rst) begin
            track_q <= 1'b0;
        end else if (bit_cnt_q == CNT_TRACK) begin
            track_q <= 1'b1;
        end else if (bit_cnt_q == CNT_FULL) begin
            track_q <= 1'b0;
        end
    end

    assign TH_TRACK = track_q;

    // Toggle keeps its level over chip select so no event is lost
    always_ff @(negedge SCLK or posedge RESET) begin
        if (RESET) begin
            conv_tgl_q <= 1'b0;
        end else if (!CS_N && bit_cnt_q == CNT_FULL) begin
            conv_tgl_q <= ~conv_tgl_q;
        end
    end

    // ------------------------------------------------------------
    // Crossing into the core domain
    // ------------------------------------------------------------
    // Byte is stable for at least seven and a half serial periods after the toggle,
    // far longer than the three core cycles needed to see it.
    logic tgl_sync;
    logic tgl_seen_q;
    logic byte_evt;

    sync_2ff #(
        .W(1)
    ) u_tgl_sync (
        .clk(CORE_CLK),
        .rst(RESET),
        .ce(CE),
        .d(conv_tgl_q),
        .q(tgl_sync)
    );

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            tgl_seen_q <= 1'b0;
        end else if (CE) begin
            tgl_seen_q <= tgl_sync;
        end
    end

    assign byte_evt = tgl_sync ^ tgl_seen_q;

    // ------------------------------------------------------------
    // Core domain: channel decode
    // ------------------------------------------------------------
    logic [2:0] sel;
    logic single;
    logic [1:0] pwr;
    logic [3:0] pos_d;
    logic [3:0] neg_d;
    logic com_d;
    logic bad_d;

    assign sel = byte_q[SEL_HI_BIT:SEL_LO_BIT];
    assign single = byte_q[INPUT_MODE_BIT];
    assign pwr = byte_q[PWR_HI_BIT:PWR_LO_BIT];

    always_comb begin
        pos_d = CH_NONE;
        neg_d = CH_NONE;
        com_d = 1'b0;
        bad_d = 1'b0;
        if (single) begin
            com_d = 1'b1;
            case (sel)
                SEL_A: pos_d = 4'h1;
                SEL_B: pos_d = 4'h2;
                SEL_C: pos_d = 4'h4;
                SEL_D: pos_d = 4'h8;
                default: bad_d = 1'b1;
            endcase
        end else begin
            case (sel)
                SEL_A: begin
                    pos_d = 4'h1;
                    neg_d = 4'h2;
                end
                SEL_C: begin
                    pos_d = 4'h4;
                    neg_d = 4'h8;
                end
                SEL_B: begin
                    pos_d = 4'h2;
                    neg_d = 4'h1;
                end
                SEL_D: begin
                    pos_d = 4'h8;
                    neg_d = 4'h4;
                end
                default: bad_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            POS_CH_SEL <= CH_NONE;
            NEG_CH_SEL <= CH_NONE;
            NEG_TO_COM <= 1'b0;
            SEL_INVALID <= 1'b0;
        end else if (CE && byte_evt) begin
            POS_CH_SEL <= pos_d;
            NEG_CH_SEL <= neg_d;
            NEG_TO_COM <= com_d;
            SEL_INVALID <= bad_d;
        end
    end

    // ------------------------------------------------------------
    // Core domain: polarity and power/clock mode
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            UNIPOLAR <= 1'b0;
            PWR_DOWN_FULL <= 1'b0;
            PWR_DOWN_FAST <= 1'b0;
            INT_CLK_MODE <= 1'b0;
            EXT_CLK_MODE <= 1'b0;
        end else if (CE && byte_evt) begin
            UNIPOLAR <= byte_q[POLARITY_BIT];
            PWR_DOWN_FULL <= (pwr == PWR_FULL_DOWN);
            PWR_DOWN_FAST <= (pwr == PWR_FAST_DOWN);
            INT_CLK_MODE <= (pwr == PWR_INT_CLK);
            EXT_CLK_MODE <= (pwr == PWR_EXT_CLK);
        end
    end

    // ------------------------------------------------------------
    // Core domain: conversion sequencing
    // ------------------------------------------------------------
    // A new byte during a conversion aborts it and starts another.
    conv_state_t state_q;
    conv_state_t state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (byte_evt) begin
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (byte_evt) begin
                    state_d = ST_CONVERT;
                end else if (CONV_DONE) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            state_q <= ST_IDLE;
        end else if (CE) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            CONV_START <= 1'b0;
            CONV_BUSY <= 1'b0;
            CHOLD_ON_NEG <= 1'b0;
        end else if (CE) begin
            CONV_START <= byte_evt;
            CONV_BUSY <= (state_d == ST_CONVERT);
            // Capacitor faces the negative side only while converting
            CHOLD_ON_NEG <= (state_d == ST_CONVERT);
        end
    end

endmodule : adc_serial_control_byte_sampler

// file: testbench/serial_master.sv
// Purpose: Serial master model that frames control bytes.
// Assumes: Mode 0 link, SCLK stands low outside frames.
// Notes:   Pauses after the fifth bit so the sampler can settle.
`timescale 1ns/10ps
module serial_master
    import adc_ctrl_pkg::*;
(
    output logic SCLK,
    output logic CS_N,
    output logic DIN
);
    // ----------------------------------------
    // Frame driver
    // ----------------------------------------
    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        DIN = 1'b0;
    end

    // Leading zeros, then nbits of b MSB first, then one spare clock
    // Frames of nbits of b, whole bytes or cut short; no reply line
    task automatic send(input logic [7:0] b, input int zeros,
                        input int nbits);
        CS_N = 1'b0;
        for (int i = 0; i < zeros + nbits + 1; i++) begin
            // Data moves on the falling edge only
            DIN = (i < zeros || i >= zeros + nbits) ? 1'b0 : b[7 + zeros - i];
            #7.5 SCLK = 1'b1;
            #7.5 SCLK = 1'b0;
            if (i == zeros + 4) #(ACQUIRE_TIME_NS);
        end
        #3.3 CS_N = 1'b1;
        // Deselected line must not look like a held value
        DIN = ~DIN;
    endtask : send
endmodule : serial_master

// file: testbench/adc_ctrl_sva.sv
// Purpose: Assertions on the control-byte front end ports.
// Assumes: Master clocks one spare bit after each full byte.
// Notes:   Bit count is rebuilt here from the link pins.
`timescale 1ns/10ps
module adc_ctrl_sva (
    input wire logic CORE_CLK,
    input wire logic RESET,
    input wire logic CE,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic DIN,
    input wire logic CONV_DONE,
    input wire logic TH_TRACK,
    input wire logic CONV_START,
    input wire logic CONV_BUSY,
    input wire logic CHOLD_ON_NEG,
    input wire logic [3:0] POS_CH_SEL,
    input wire logic [3:0] NEG_CH_SEL,
    input wire logic NEG_TO_COM,
    input wire logic SEL_INVALID
);
    // ----------------------------------------
    // Link bit counter and checks
    // ----------------------------------------
    logic [3:0] bit_cnt_q;
    always_ff @(posedge SCLK or posedge CS_N or posedge RESET) begin
        if (RESET || CS_N) begin
            bit_cnt_q <= 4'h0;
        end else if (bit_cnt_q == 4'h0 || bit_cnt_q == 4'h8) begin
            bit_cnt_q <= {3'h0, DIN};
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    chk_track_window:
    assert property (@(posedge SCLK) disable iff (RESET || CS_N)
        bit_cnt_q inside {[4'h5:4'h7]} |-> TH_TRACK)
        else $error("tracking missing after fifth bit");
    chk_early_idle:
    assert property (@(posedge SCLK) disable iff (RESET || CS_N)
        bit_cnt_q inside {[4'h1:4'h4]} |-> !TH_TRACK)
        else $error("tracking before fifth bit");
    chk_hold_eighth:
    assert property (@(posedge SCLK) disable iff (RESET || CS_N)
        bit_cnt_q == 4'h8 |-> !TH_TRACK)
        else $error("no hold after eighth bit");
    chk_start_single:
    assert property (@(posedge CORE_CLK) disable iff (RESET)
        CONV_START && CE |=> !CONV_START)
        else $error("start pulse longer than one cycle");
    chk_start_busy:
    assert property (@(posedge CORE_CLK) disable iff (RESET)
        CONV_START |-> CONV_BUSY && CHOLD_ON_NEG)
        else $error("start without busy and hold switch");
    chk_single_com:
    assert property (@(posedge CORE_CLK) disable iff (RESET)
        CONV_START && NEG_TO_COM |-> NEG_CH_SEL == 4'h0)
        else $error("negative channel set in single mode");
    chk_diff_pair:
    assert property (@(posedge CORE_CLK) disable iff (RESET)
        CONV_START && !NEG_TO_COM && !SEL_INVALID |-> $onehot(NEG_CH_SEL)
        && (POS_CH_SEL | NEG_CH_SEL) inside {4'h3, 4'hC})
        else $error("differential pair malformed");
    chk_invalid_none:
    assert property (@(posedge CORE_CLK) disable iff (RESET)
        CONV_START && SEL_INVALID |-> (POS_CH_SEL | NEG_CH_SEL) == 4'h0)
        else $error("channel chosen for invalid code");
    chk_done_release:
    assert property (@(posedge CORE_CLK) disable iff (RESET)
        CONV_BUSY && CONV_DONE && CE |=> !CHOLD_ON_NEG || CONV_START)
        else $error("hold cap not returned after done");

    cov_single: cover property (@(posedge CORE_CLK) CONV_START && NEG_TO_COM);
    cov_diff: cover property (@(posedge CORE_CLK) CONV_START && !NEG_TO_COM);
    cov_done: cover property (@(posedge CORE_CLK) CONV_BUSY && CONV_DONE);
endmodule : adc_ctrl_sva

bind adc_serial_control_byte_sampler adc_ctrl_sva chk (.*);

// file: testbench/adc_serial_control_byte_sampler_tb.sv
// Purpose: Self-checking bench for the control-byte front end.
// Assumes: Serial master model drives the link; CE drops in some runs.
// Notes:   Random bytes cover every select code and both input modes.
`timescale 1ns/10ps
module adc_serial_control_byte_sampler_tb import adc_ctrl_pkg::*;;
    logic CORE_CLK = 1'b0;
    logic RESET = 1'b0;
    logic CE = 1'b1;
    logic CONV_DONE = 1'b0;
    logic SCLK, CS_N, DIN, TH_TRACK, CONV_START, CONV_BUSY, CHOLD_ON_NEG;
    logic NEG_TO_COM, SEL_INVALID, UNIPOLAR, PWR_DOWN_FULL, PWR_DOWN_FAST;
    logic INT_CLK_MODE, EXT_CLK_MODE;
    logic [3:0] POS_CH_SEL, NEG_CH_SEL;
    int failures = 0;
    int tests_run = 0;
    int starts = 0;
    int seed = 32'h52758345;

    always #10 CORE_CLK = ~CORE_CLK;
    always @(negedge CORE_CLK) if (CONV_START === 1'b1) starts++;

    serial_master master (.SCLK(SCLK), .CS_N(CS_N), .DIN(DIN));
    adc_serial_control_byte_sampler dut (.*);

    // ----------------------------------------
    // Checks and expectations
    // ----------------------------------------
    task automatic close_out;
        $display("Checks %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Returns {invalid, to_common, negative, positive}
    function automatic logic [9:0] exp_mux(input logic [7:0] b);
        logic [3:0] p;
        logic [3:0] m;
        p = 4'h0;
        m = 4'h0;
        case (b[6:4])
            SEL_A: begin p = 4'h1; m = 4'h2; end
            SEL_B: begin p = 4'h2; m = 4'h1; end
            SEL_C: begin p = 4'h4; m = 4'h8; end
            SEL_D: begin p = 4'h8; m = 4'h4; end
            default: ;
        endcase
        if (b[2]) m = 4'h0;
        return {p == 4'h0, b[2], m, p};
    endfunction : exp_mux

    // Absence checks use the full bound on purpose
    task automatic wait_start(input int n0, input int want);
        int t;
        t = 0;
        while (starts == n0 && t < 40) begin
            @(negedge CORE_CLK);
            t++;
        end
        check("start count", 16'(starts - n0), 16'(want));
        if (want == 1 && t == 40) close_out();
    endtask : wait_start

    task automatic run_byte(input logic [7:0] b, input int zeros,
                            input bit freeze);
        logic [9:0] e;
        int n0;
        n0 = starts;
        CE = !freeze;
        master.send(b, zeros, 8);
        if (freeze) begin
            // Core must hold the pending byte until CE returns
            repeat (10) @(negedge CORE_CLK);
            check("frozen start", 16'(starts - n0), 16'h0);
            CE = 1'b1;
        end
        wait_start(n0, 1);
        e = exp_mux(b);
        if (e[9] === 1'b0)
            check("mux", 16'({SEL_INVALID, NEG_TO_COM, NEG_CH_SEL,
                POS_CH_SEL}), 16'(e));
        else
            check("none", 16'({SEL_INVALID, NEG_CH_SEL, POS_CH_SEL}),
                16'h100);
        check("polarity", 16'(UNIPOLAR), 16'(b[3]));
        check("power", 16'({PWR_DOWN_FULL, PWR_DOWN_FAST, INT_CLK_MODE,
            EXT_CLK_MODE}), 16'(4'h8 >> b[1:0]));
        check("hold", 16'({CONV_BUSY, CHOLD_ON_NEG, TH_TRACK}), 16'h6);
        CONV_DONE = 1'b1;
        @(negedge CORE_CLK);
        CONV_DONE = 1'b0;
        check("released", 16'({CONV_BUSY, CHOLD_ON_NEG}), 16'h0);
    endtask : run_byte

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] b;
        logic [31:0] r;
        // Reset rises after time zero so every async reset sees an edge
        @(negedge CORE_CLK);
        RESET = 1'b1;
        repeat (8) @(negedge CORE_CLK);
        RESET = 1'b0;
        @(negedge CORE_CLK);
        master.send(8'h00, 12, 0);
        wait_start(starts, 0);
        master.send(8'hFF, 1, 4);
        wait_start(starts, 0);
        run_byte(8'hDF, 0, 1'b1);
        RESET = 1'b1;
        @(negedge CORE_CLK);
        check("reset", 16'({CONV_BUSY, UNIPOLAR, POS_CH_SEL}), 16'h0);
        RESET = 1'b0;
        @(negedge CORE_CLK);
        for (int k = 0; k < 16; k++) begin
            r = $random(seed);
            b = {1'b1, k[2:0], r[0], k[3], k[1:0] ^ k[3:2]};
            run_byte(b, int'(r[2:1]), r[3]);
        end
        close_out();
    end
endmodule : adc_serial_control_byte_sampler_tb
